//--- hdl/ewg_link.sv
// Serial-clock side: frame bit count, header capture and status shift-out
`timescale 1ns/1ns
module ewg_link
   import ewg_pkg::*;
(
   input  wire logic                    sck,
   input  wire logic                    selectN,
   input  wire logic                    serialIn,
   input  wire logic [7:0]              statusSnap,
   output logic      [ewg_pkg::CNT_W-1:0] frameBits,
   output logic      [7:0]              cmdByte,
   output logic      [7:0]              addrByte,
   output logic                         serialOut,
   output logic                         serialOutEn
);
   logic inFrame;

   // The serial clock stops between frames, so the frame's own select ends it
   always_ff @(posedge sck or posedge selectN) begin
      if (selectN) begin
         inFrame <= 1'b0;
      end else begin
         inFrame <= 1'b1;
      end
   end

   // Count and header hold after select rises so the core can read them
   always_ff @(posedge sck) begin
      if (!inFrame) begin
         frameBits <= CNT_W'(1);
         cmdByte   <= {cmdByte[6:0], serialIn};
      end else begin
         if (frameBits != BITS_SAT) begin
            frameBits <= frameBits + CNT_W'(1);
         end
         if (frameBits < BITS_CMD) begin
            cmdByte <= {cmdByte[6:0], serialIn};
         end else if (frameBits < BITS_STATUS_WR) begin
            addrByte <= {addrByte[6:0], serialIn};
         end
      end
   end

   // Output only while selected; select high forces high impedance
   always_ff @(negedge sck or posedge selectN) begin
      if (selectN) begin
         serialOutEn <= 1'b0;
         serialOut   <= 1'b0;
      end else if (inFrame && frameBits >= BITS_CMD && cmdByte == STATUS_READ_CMD) begin
         serialOutEn <= 1'b1;
         serialOut   <= statusSnap[3'd7 - frameBits[BYTE_LSB_W-1:0]];
      end
   end
endmodule

//--- hdl/ewg_pkg.sv
// Shared constants and types of the write guard
package ewg_pkg;
   // Instruction codes seen in the first byte of a frame
   localparam logic [7:0] LATCH_SET_CMD   = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] ARRAY_WRITE_PAT = 8'h02;
   localparam logic [7:0] ARRAY_WRITE_MSK = 8'hf7;
   localparam int         ADDR_HI_BIT     = 3;

   // Frame lengths in serial clock cycles
   localparam int         CNT_W           = 8;
   localparam logic [7:0] BITS_CMD        = 8'h08;
   localparam logic [7:0] BITS_STATUS_WR  = 8'h10;
   localparam logic [7:0] BITS_WRITE_MIN  = 8'h20;
   localparam logic [7:0] BITS_HEADER     = 8'h18;
   localparam logic [7:0] BITS_SAT        = 8'hff;
   localparam int         BYTE_LSB_W      = 3;
   localparam logic [4:0] PAGE_BYTES      = 5'h10;

   // Status byte layout
   localparam int         ST_ACTIVE_BIT   = 0;
   localparam int         ST_LATCH_BIT    = 1;
   localparam int         ST_GUARD_LO_BIT = 2;
   localparam int         ST_GUARD_HI_BIT = 3;
   localparam int         ST_GUARD_W      = 2;

   // Protected region starts
   localparam int         ADDR_W          = 9;
   localparam logic [8:0] QUARTER_BASE    = 9'h180;
   localparam logic [8:0] HALF_BASE       = 9'h100;
   localparam logic [1:0] GUARD_RESET     = 2'h0;

   typedef enum logic [1:0] {
      GUARD_NONE    = 2'b00,
      GUARD_QUARTER = 2'b01,
      GUARD_HALF    = 2'b10,
      GUARD_ALL     = 2'b11
   } ewg_guard_e;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_ACTIVE  = 2'b01,
      ST_PROGRAM = 2'b10
   } ewg_state_e;

   // Self-timed programming cycle
   localparam int         CORE_PERIOD_NS  = 100;
   localparam int         WRITE_CYCLE_NS  = 5000000;
   localparam int         WRITE_CYCLES    = WRITE_CYCLE_NS / CORE_PERIOD_NS;
   localparam int         TIMER_W         = 20;
endpackage

//--- hdl/ewg_sync.sv
// Two-stage synchroniser for pin levels entering the core clock
`timescale 1ns/1ns
module ewg_sync #(
   parameter int                 W         = 1,
   parameter logic [W-1:0]       RESET_VAL = '0
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [W-1:0]     async_in,
   output logic      [W-1:0]     sync_out
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

//--- hdl/ewg_top.sv
// Write-enable latch, block protection and programming-cycle control
`timescale 1ns/1ns
module ewg_top
   import ewg_pkg::*;
#(
   parameter int WRITE_CYCLE_COUNT = ewg_pkg::WRITE_CYCLES
) (
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     sck,
   input  wire logic                     selectN,
   input  wire logic                     serialIn,
   input  wire logic                     writeProtectN,
   output logic                          serialOut,
   output logic                          serialOutEn,
   output logic                          writeLatchFlag,
   output logic                          writeActiveFlag,
   output logic                          blockGuardLow,
   output logic                          blockGuardHigh,
   output logic [7:0]                    statusByte,
   output logic                          deviceActive,
   output logic                          arrayWriteStart,
   output logic                          statusWriteStart,
   output logic [ewg_pkg::ADDR_W-1:0]    writeAddr,
   output logic [4:0]                    writeBytes
);
   import ewg_pkg::*;

   logic [CNT_W-1:0]   linkBits;
   logic [7:0]         linkCmd;
   logic [7:0]         linkAddr;
   logic [1:0]         pinSync;
   logic               selSync;
   logic               wpSync;
   logic               selPrev_q;
   logic               frameEnd;
   logic               frameOpen;
   ewg_state_e         state_q;
   ewg_state_e         state_d;
   logic [TIMER_W-1:0] timer_q;
   logic               timerDone;
   logic               latch_q;
   logic [1:0]         guard_q;
   logic [ADDR_W-1:0]  frameAddr;
   logic               setCmd;
   logic               clearCmd;
   logic               statusWrOk;
   logic               arrayWrOk;
   logic               startProg;
   logic [7:0]         statusSnap_q;

   // Data bytes of a frame, capped at one page because the address wraps inside it
   function automatic logic [4:0] bytesInFrame(input logic [CNT_W-1:0] bits);
      logic [CNT_W-1:0] dataBits;
      logic [4:0]       count;
      dataBits = bits - BITS_HEADER;
      count    = 5'(dataBits >> BYTE_LSB_W);
      return (count > PAGE_BYTES) ? PAGE_BYTES : count;
   endfunction

   // Guard bits against a write start address; regions are page aligned
   function automatic logic addrProtected(input logic [1:0] guard,
                                          input logic [ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (ewg_guard_e'(guard))
         GUARD_NONE:    hit = 1'b0;
         GUARD_QUARTER: hit = (addr >= QUARTER_BASE);
         GUARD_HALF:    hit = (addr >= HALF_BASE);
         GUARD_ALL:     hit = 1'b1;
      endcase
      return hit;
   endfunction

   // Instruction-only frames: eight clocks and nothing after the opcode
   function automatic logic shortCmd(input logic [CNT_W-1:0] bits,
                                     input logic [7:0]       cmd,
                                     input logic [7:0]       code);
      return bits == BITS_CMD && cmd == code;
   endfunction

   // One status layout serves both the port and the serial shift-out
   function automatic logic [7:0] statusWord(input logic [1:0] guard,
                                             input logic       latch,
                                             input ewg_state_e state);
      return {4'h0, guard, latch, state == ST_PROGRAM};
   endfunction

   ewg_sync #(
      .W         (2),
      .RESET_VAL (2'b11)
   ) u_pin_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in ({selectN, writeProtectN}),
      .sync_out (pinSync)
   );

   assign selSync = pinSync[1];
   assign wpSync  = pinSync[0];

   ewg_link u_link (
      .sck         (sck),
      .selectN     (selectN),
      .serialIn    (serialIn),
      .statusSnap  (statusSnap_q),
      .frameBits   (linkBits),
      .cmdByte     (linkCmd),
      .addrByte    (linkAddr),
      .serialOut   (serialOut),
      .serialOutEn (serialOutEn)
   );

   // Link words are read only after select has risen and crossed, when sck is idle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         selPrev_q <= 1'b1;
      end else begin
         selPrev_q <= selSync;
      end
   end

   assign frameEnd  = selSync && !selPrev_q;
   assign frameOpen = !selSync;
   assign frameAddr = {linkCmd[ADDR_HI_BIT], linkAddr};

   assign setCmd   = frameEnd && shortCmd(linkBits, linkCmd, LATCH_SET_CMD);
   assign clearCmd = frameEnd && shortCmd(linkBits, linkCmd, LATCH_CLEAR_CMD);

   // Status write: exactly sixteen clocks, protect pin high, latch set
   assign statusWrOk = frameEnd && state_q != ST_PROGRAM
                       && linkCmd == STATUS_WRITE_CMD && linkBits == BITS_STATUS_WR
                       && wpSync && latch_q;

   // Array write: header plus whole data bytes, start block unprotected
   assign arrayWrOk = frameEnd && state_q != ST_PROGRAM
                      && (linkCmd & ARRAY_WRITE_MSK) == ARRAY_WRITE_PAT
                      && linkBits >= BITS_WRITE_MIN
                      && linkBits[BYTE_LSB_W-1:0] == '0
                      && wpSync && latch_q
                      && !addrProtected(guard_q, frameAddr);

   assign startProg = statusWrOk || arrayWrOk;
   assign timerDone = state_q == ST_PROGRAM && timer_q == '0;

   // Standby until select goes low; programming runs to its end regardless
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_STANDBY: begin
            if (frameOpen) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (startProg) begin
               state_d = ST_PROGRAM;
            end else if (!frameOpen) begin
               state_d = ST_STANDBY;
            end
         end
         ST_PROGRAM: begin
            if (timerDone) begin
               state_d = frameOpen ? ST_ACTIVE : ST_STANDBY;
            end
         end
         default: state_d = ST_STANDBY;
      endcase
   end

   // Reset leaves the device in standby, as if select had just been released
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= ST_STANDBY;
      end else begin
         state_q <= state_d;
      end
   end

   // Self-timed cycle length
   // Reloaded only by an accepted write, so a cut frame never starts a cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         timer_q <= '0;
      end else if (startProg) begin
         timer_q <= TIMER_W'(WRITE_CYCLE_COUNT - 1);
      end else if (state_q == ST_PROGRAM && timer_q != '0) begin
         timer_q <= timer_q - TIMER_W'(1);
      end
   end

   // A set in the same cycle as a completion wins; protect pin low always clears
   always_ff @(posedge core_clk) begin
      if (reset) begin
         latch_q <= 1'b0;
      end else if (!wpSync) begin
         latch_q <= 1'b0;
      end else if (setCmd) begin
         latch_q <= 1'b1;
      end else if (clearCmd || timerDone) begin
         latch_q <= 1'b0;
      end
   end

   // Guard bits model nonvolatile cells; reset value stands for the stored one
   always_ff @(posedge core_clk) begin
      if (reset) begin
         guard_q <= GUARD_RESET;
      end else if (statusWrOk) begin
         guard_q <= linkAddr[ST_GUARD_HI_BIT:ST_GUARD_LO_BIT];
      end
   end

   // Start pulses last one cycle; the sequencer latches what it needs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         arrayWriteStart  <= 1'b0;
         statusWriteStart <= 1'b0;
      end else begin
         arrayWriteStart  <= arrayWrOk;
         statusWriteStart <= statusWrOk;
      end
   end

   // Start address and length hold until the next accepted array write
   always_ff @(posedge core_clk) begin
      if (reset) begin
         writeAddr  <= '0;
         writeBytes <= '0;
      end else if (arrayWrOk) begin
         writeAddr  <= frameAddr;
         writeBytes <= bytesInFrame(linkBits);
      end
   end

   // Port flags are registered copies of the internal state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         writeLatchFlag <= 1'b0;
      end else begin
         writeLatchFlag <= latch_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         writeActiveFlag <= 1'b0;
      end else begin
         writeActiveFlag <= state_q == ST_PROGRAM;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         blockGuardLow  <= 1'b0;
         blockGuardHigh <= 1'b0;
      end else begin
         blockGuardLow  <= guard_q[0];
         blockGuardHigh <= guard_q[1];
      end
   end

   // Standby only when deselected and not programming
   always_ff @(posedge core_clk) begin
      if (reset) begin
         deviceActive <= 1'b0;
      end else begin
         deviceActive <= state_q != ST_STANDBY;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         statusByte <= '0;
      end else begin
         statusByte <= statusWord(guard_q, latch_q, state_q);
      end
   end

   // Snapshot for shift-out frozen while selected: the link reads it without a crossing
   always_ff @(posedge core_clk) begin
      if (reset) begin
         statusSnap_q <= '0;
      end else if (selSync) begin
         statusSnap_q <= statusWord(guard_q, latch_q, state_q);
      end
   end
endmodule

//--- testbench/ewg_host_model.sv
// Host serial master that sends frames and captures the status byte
`timescale 1ns/1ns
module ewg_host_model (
   input  wire logic core_clk,
   input  wire logic serialOut,
   input  wire logic serialOutEn,
   output logic      sck,
   output logic      selectN,
   output logic      serialIn
);
   localparam int HALF_NS = 80;
   wire logic soLine = serialOutEn ? serialOut : 1'bz;
   // Select rises from its unpowered low level, which gives the link its clearing edge
   initial begin
      sck = 1'b0;
      selectN = 1'b0;
      serialIn = 1'b0;
      #1 selectN = 1'b1;
   end
   // Clock stays low between frames; bits go out MSB first
   task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge core_clk);
      #2 selectN = 1'b0;
      for (int i = 0; i < n; i++) begin
         serialIn = (i < 40) ? bits[39 - i] : 1'b0;
         #HALF_NS sck = 1'b1;
         if (i >= 8 && i < 16) rd = {rd[6:0], soLine};
         #HALF_NS sck = 1'b0;
      end
      #HALF_NS selectN = 1'b1;
      // A released data line must not keep looking valid
      serialIn = ~serialIn;
      #1000;
   endtask
endmodule

//--- testbench/ewg_top_props.sv
// Port-level checks of the write guard
`timescale 1ns/1ns
module ewg_top_props
   import ewg_pkg::*;
#(
   parameter int WRITE_CYCLE_COUNT = ewg_pkg::WRITE_CYCLES
) (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       selectN,
   input wire logic       writeProtectN,
   input wire logic       serialOutEn,
   input wire logic       writeLatchFlag,
   input wire logic       writeActiveFlag,
   input wire logic       blockGuardLow,
   input wire logic       blockGuardHigh,
   input wire logic [7:0] statusByte,
   input wire logic       deviceActive,
   input wire logic       arrayWriteStart,
   input wire logic       statusWriteStart
);
   logic [19:0] activeCnt_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Counts cycles of one programming run; cleared while idle
   always_ff @(posedge core_clk) begin
      if (reset || !writeActiveFlag) activeCnt_q <= 20'h0;
      else activeCnt_q <= activeCnt_q + 20'h1;
   end
   AST_ARRAY_NEEDS_LATCH: assert property (arrayWriteStart |-> writeLatchFlag && !writeActiveFlag)
      else $error("array write accepted while not permitted");
   AST_STATUS_NEEDS_LATCH: assert property (statusWriteStart |-> writeLatchFlag && !writeActiveFlag)
      else $error("status write accepted while not permitted");
   AST_PROTECT_HOLDS: assert property (!writeProtectN [*6] |-> !writeLatchFlag)
      else $error("latch set while protect pin low");
   AST_PROG_CAUSE: assert property ($rose(writeActiveFlag) |-> $past(arrayWriteStart || statusWriteStart))
      else $error("programming began without an accepted write");
   AST_START_RUNS: assert property (arrayWriteStart |=> writeActiveFlag && !arrayWriteStart)
      else $error("accepted write did not start programming");
   AST_PROG_LENGTH: assert property ($fell(writeActiveFlag) |-> activeCnt_q == 20'(WRITE_CYCLE_COUNT))
      else $error("programming run length wrong");
   AST_LATCH_AT_END: assert property ($fell(writeActiveFlag) |-> !writeLatchFlag)
      else $error("latch still set after programming");
   AST_STATUS_MAP: assert property (statusByte == {4'h0, blockGuardHigh, blockGuardLow, writeLatchFlag, writeActiveFlag})
      else $error("status byte does not match flags");
   AST_OUT_RELEASED: assert property (selectN |-> !serialOutEn)
      else $error("serial output driven while deselected");
   AST_STANDBY: assert property ((selectN && !writeActiveFlag) [*8] |-> !deviceActive)
      else $error("active while deselected and idle");
   AST_ACTIVE_ON_SELECT: assert property (!selectN [*5] |-> deviceActive)
      else $error("still in standby while selected");
endmodule
bind ewg_top ewg_top_props #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) u_ewg_top_props (.core_clk,
   .reset, .selectN, .writeProtectN, .serialOutEn, .writeLatchFlag, .writeActiveFlag,
   .blockGuardLow, .blockGuardHigh, .statusByte, .deviceActive, .arrayWriteStart,
   .statusWriteStart);

//--- testbench/test_eeprom_write_guard.sv
// Directed frame-level test of the write guard
`timescale 1ns/1ns
module test_eeprom_write_guard;
   import ewg_pkg::*;
   localparam int CYC = 400;
   logic       core_clk, reset, writeProtectN, sck, selectN, serialIn, serialOut, serialOutEn;
   logic       writeLatchFlag, writeActiveFlag, blockGuardLow, blockGuardHigh, deviceActive;
   logic       arrayWriteStart, statusWriteStart;
   logic [7:0] statusByte, rd;
   logic [8:0] writeAddr;
   logic [4:0] writeBytes;
   logic [9:0] lim;
   logic [8:0] addrs [3] = '{9'h0ff, 9'h17f, 9'h180};
   int         failCount, checks, arrayStarts, statusStarts, expStarts;
   ewg_top #(.WRITE_CYCLE_COUNT(CYC)) u_ewg_top (.core_clk(core_clk), .reset(reset), .sck(sck),
      .selectN(selectN), .serialIn(serialIn), .writeProtectN(writeProtectN),
      .serialOut(serialOut), .serialOutEn(serialOutEn), .writeLatchFlag(writeLatchFlag),
      .writeActiveFlag(writeActiveFlag), .blockGuardLow(blockGuardLow),
      .blockGuardHigh(blockGuardHigh), .statusByte(statusByte), .deviceActive(deviceActive),
      .arrayWriteStart(arrayWriteStart), .statusWriteStart(statusWriteStart),
      .writeAddr(writeAddr), .writeBytes(writeBytes));
   ewg_host_model u_ewg_host_model (.core_clk(core_clk), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .sck(sck), .selectN(selectN), .serialIn(serialIn));
   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (arrayWriteStart === 1'b1) arrayStarts++;
      if (statusWriteStart === 1'b1) statusStarts++;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic frame(input logic [39:0] bits, input int n);
      u_ewg_host_model.xfer(bits, n, rd);
      cyc(8);
   endtask
   // Bounded wait for the self-timed cycle to finish
   task automatic idle;
      for (int i = 0; i < CYC + 100 && writeActiveFlag !== 1'b0; i++) cyc(1);
      if (writeActiveFlag !== 1'b0) begin
         failCount++;
         stop_test;
      end
      cyc(10);
   endtask
   initial begin
      reset = 1'b1;
      writeProtectN = 1'b1;
      {failCount, checks, arrayStarts, statusStarts, expStarts} = '0;
      cyc(16);
      reset = 1'b0;
      cyc(2);
      check(16'({serialOutEn, writeLatchFlag, deviceActive, statusByte}), 16'h0);
      frame({8'h02, 8'ha5, 8'h5a, 16'h0}, 32);
      check(16'(arrayStarts), 16'h0);
      frame({LATCH_SET_CMD, 32'h0}, 8);
      check(16'(statusByte), 16'h02);
      frame({LATCH_CLEAR_CMD, 32'h0}, 8);
      check(16'(writeLatchFlag), 16'h0);
      frame({LATCH_SET_CMD, 32'h0}, 8);
      frame({8'h02, 8'h10, 8'h33, 16'h0}, 36);
      check(16'({arrayStarts[3:0], writeLatchFlag}), 16'h1);
      frame({8'h0a, 8'ha5, 8'h5a, 16'h0}, 32);
      check(16'({arrayStarts[1:0], writeAddr, writeBytes}), {2'h1, 9'h1a5, 5'h01});
      frame({STATUS_READ_CMD, 32'h0}, 16);
      check(16'(rd), 16'h03);
      frame({8'h02, 8'h20, 8'h44, 16'h0}, 32);
      check(16'(arrayStarts), 16'h1);
      idle;
      check(16'(statusByte), 16'h0);
      // Twenty data bytes wrap inside one page, so sixteen are written
      frame({LATCH_SET_CMD, 32'h0}, 8);
      frame({8'h02, 8'h40, 24'h0}, 184);
      check(16'({arrayStarts[1:0], writeAddr, writeBytes}), {2'h2, 9'h040, 5'h10});
      idle;
      expStarts = 2;
      for (int g = 0; g < 4; g++) begin
         frame({LATCH_SET_CMD, 32'h0}, 8);
         frame({STATUS_WRITE_CMD, 4'h0, 2'(g), 2'b00, 24'h0}, 16);
         idle;
         check(16'({statusStarts[3:0], blockGuardHigh, blockGuardLow, writeLatchFlag}),
               16'({4'(g + 1), 2'(g), 1'b0}));
         lim = (g == 0) ? 10'h200 : (g == 1) ? 10'h180 : (g == 2) ? 10'h100 : 10'h000;
         for (int k = 0; k < 3; k++) begin
            frame({LATCH_SET_CMD, 32'h0}, 8);
            frame({4'h0, addrs[k][8], 3'b010, addrs[k][7:0], 8'h5a, 16'h0}, 32);
            if ({1'b0, addrs[k]} < lim) expStarts++;
            check(16'(arrayStarts), 16'(expStarts));
            idle;
         end
      end
      frame({LATCH_SET_CMD, 32'h0}, 8);
      writeProtectN = 1'b0;
      cyc(8);
      check(16'(writeLatchFlag), 16'h0);
      frame({LATCH_SET_CMD, 32'h0}, 8);
      writeProtectN = 1'b1;
      cyc(8);
      check(16'(writeLatchFlag), 16'h0);
      frame({LATCH_SET_CMD, 32'h0}, 8);
      reset = 1'b1;
      cyc(4);
      reset = 1'b0;
      cyc(2);
      check(16'({writeLatchFlag, deviceActive, statusByte}), 16'h0);
      stop_test;
   end
endmodule
